// ### lvm_host_model.sv
// Host model that writes registers and reads them back byte by byte
`timescale 1ns/1ps
module lvm_host_model
  import lvm_pkg::*;
(
  input wire logic i_sys_clk,
  input wire lvm_rsp_t i_rsp,
  output lvm_req_t o_req
);
  int proto_err = 0;
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Nothing requested at time zero
  initial o_req = '0;
  // Released lines show the inverse, so a stale copy is never seen
  task automatic release_bus();
    o_req.addr = ~o_req.addr;
    o_req.wdata = ~o_req.wdata;
  endtask
  // One-cycle write strobe, no answer comes back
  task automatic write_reg(input logic [5:0] addr, input logic [15:0] data);
    @(posedge i_sys_clk);
    #1;
    o_req.wr = 1'b1;
    o_req.addr = addr;
    o_req.wdata = data;
    @(posedge i_sys_clk);
    #1;
    o_req.wr = 1'b0;
    release_bus();
  endtask
  // Takes every byte, most significant first, one ack each
  task automatic read_reg(input logic [5:0] addr, input int nbytes, output logic [23:0] val);
    val = '0;
    @(posedge i_sys_clk);
    #1;
    o_req.rd = 1'b1;
    o_req.addr = addr;
    @(posedge i_sys_clk);
    #1;
    o_req.rd = 1'b0;
    for (int i = 0; i < nbytes; i++) begin
      if (i_rsp.valid !== 1'b1) begin
        $display("ERROR t=%0t got=%h exp=%h", $time, i_rsp.valid, 1'b1);
        proto_err++;
      end
      val = {val[15:0], i_rsp.data};
      o_req.ack = 1'b1;
      @(posedge i_sys_clk);
      #1;
    end
    o_req.ack = 1'b0;
    if (i_rsp.valid !== 1'b0) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, i_rsp.valid, 1'b0);
      proto_err++;
    end
    release_bus();
  endtask
endmodule

// ### lvm_monitor.sv
// Voltage channel event monitor: smoothing, crossings, timeouts, period, dip and peak
`timescale 1ns/1ps
`include "lvm_regs.svh"

module lvm_monitor
  import lvm_pkg::*;
#(
  parameter int FILT_SHIFT = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_vsample_valid,
  input wire logic [2:0][15:0] i_vsample,
  input wire logic [2:0] i_mod_vbit,
  input wire lvm_req_t i_req,
  output logic o_vsample_ready,
  output logic [2:0] o_mult_vbit,
  output lvm_rsp_t o_rsp,
  output logic o_irq_n
);

  lvm_state_t st;
  lvm_state_t next_st;

  // Helpers shared by the logic and its checks
  logic take;
  logic [2:0] zx_rise;
  logic [2:0][8:0] vabs;
  logic [1:0] per_ph;
  logic [1:0] pk_ph;
  logic [15:0] wave_pick;
  logic [1:0] rate;
  logic rd_read_clear_status;
  logic [2:0] in_fs;
  logic [2:0] filt_fs;

  // Per-phase detection terms
  always_comb begin
    take = i_vsample_valid && st.in_ready;
    per_ph = (st.measurement_mode[`LVM_MM_PERSEL +: 2] == 2'h3) ? 2'h0 : st.measurement_mode[`LVM_MM_PERSEL +: 2];
    pk_ph = (st.measurement_mode[`LVM_MM_PKSEL +: 2] == 2'h3) ? 2'h0 : st.measurement_mode[`LVM_MM_PKSEL +: 2];
    rate = st.wmode[`LVM_WM_RATE +: 2];
    rd_read_clear_status = i_req.rd && (i_req.addr == `LVM_ADDR_READ_CLEAR_STATUS);
    for (int p = 0; p < 3; p++) begin
      // Crossings taken from the smoothed value so modulator noise cannot chatter them
      zx_rise[p] = take && st.prev_neg[p] && !st.filt[p][15];
      // Absolute value of the top byte, nine bits so that -128 does not wrap
      vabs[p] = st.filt[p][15] ? (9'h000 - {st.filt[p][15], st.filt[p][15:8]})
                               : {1'b0, st.filt[p][15:8]};
      // Full-scale window of the offered sample and of the smoothed code
      in_fs[p] = $signed(i_vsample[p]) <= $signed(`LVM_FS_MAX) && $signed(i_vsample[p]) >= $signed(`LVM_FS_MIN);
      filt_fs[p] = $signed(st.filt[p]) <= $signed(`LVM_FS_MAX) && $signed(st.filt[p]) >= $signed(`LVM_FS_MIN);
    end
    case (st.wmode[`LVM_WM_PHSEL +: 2])
      2'h1: wave_pick = st.filt[1];
      2'h2: wave_pick = st.filt[2];
      default: wave_pick = st.filt[0];
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [16:0] diff;
    logic [16:0] step;
    logic push;
    logic pop;
    logic [2:0] mask;
    logic [10:0] set;
    logic [15:0] word;
    next_st = st;
    diff = 17'h00000;
    step = 17'h00000;
    set = 11'h000;
    word = 16'h0000;
    mask = 3'h0;
    push = 1'b0;
    pop = 1'b0;
    // Modulator bits go to the multiplier untouched
    next_st.mult_bit = i_mod_vbit;

    // Shared tick dividers for timeout and period counting
    next_st.tick_to = (st.tick_to == 9'(`LVM_TOUT_TICK - 1)) ? 9'h000 : st.tick_to + 9'h001;
    next_st.tick_per = (st.tick_per == 5'(`LVM_PER_TICK - 1)) ? 5'h00 : st.tick_per + 5'h01;

    for (int p = 0; p < 3; p++) begin
      if (take) begin
        // Single-pole smoother, y += (x - y) >> k; k sets the 260 Hz pole
        diff = {i_vsample[p][15], i_vsample[p]} - {st.filt[p][15], st.filt[p]};
        step = 17'($signed(diff) >>> FILT_SHIFT);
        next_st.filt[p] = st.filt[p] + step[15:0];
        next_st.prev_neg[p] = st.filt[p][15];
        // Dip: count half cycles in which every sample stayed below the level
        if (st.filt[p][15] != st.prev_neg[p]) begin
          if (st.all_below[p]) begin
            next_st.dip_cnt[p] = (st.dip_cnt[p] == 8'hff) ? 8'hff : st.dip_cnt[p] + 8'h01;
            if (st.dip_cnt[p] + 8'h01 == st.dip_cyc) begin
              set[`LVM_ST_DIP + p] = 1'b1;
            end
          end else begin
            next_st.dip_cnt[p] = 8'h00;
          end
          next_st.all_below[p] = ({1'b0, st.dip_lvl} > vabs[p]);
        end else if (!({1'b0, st.dip_lvl} > vabs[p])) begin
          next_st.all_below[p] = 1'b0;
        end
      end
      // Timeout counter: reload on crossing, else step down at each tick
      if (zx_rise[p]) begin
        next_st.tout[p] = st.zx_reload;
      end else if (st.tick_to == 9'h000 && st.tout[p] != 16'h0000) begin
        next_st.tout[p] = st.tout[p] - 16'h0001;
        if (st.tout[p] == 16'h0001) begin
          set[`LVM_ST_CROSSING_TIMEOUT_FLAG + p] = 1'b1;
        end
      end
      if (zx_rise[p] && st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + p]) begin
        set[`LVM_ST_ZX + p] = 1'b1;
      end
      // A disabled phase keeps its timeout flag up
      if (!st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + p]) begin
        set[`LVM_ST_CROSSING_TIMEOUT_FLAG + p] = 1'b1;
      end
    end

    // Peak on the one selected phase
    if (take && (vabs[pk_ph] > {1'b0, st.voltage_peak_threshold})) begin
      set[`LVM_ST_PKV] = 1'b1;
    end

    // Period counter in 24-clock units, latched at the selected phase crossing
    if (zx_rise[per_ph] && st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + per_ph]) begin
      next_st.period = st.per_cnt;
      next_st.per_cnt = 15'h0000;
    end else if (st.tick_per == 5'h00 && st.per_cnt != 15'h7fff) begin
      next_st.per_cnt = st.per_cnt + 15'h0001;
    end

    // Decimation of smoothed samples to the chosen waveform rate
    mask = 3'((4'h1 << rate) - 4'h1);
    push = take && ((st.dec_cnt & mask) == 3'h0);
    if (take) begin
      next_st.dec_cnt = st.dec_cnt + 3'h1;
    end
    // Waveform register drains the buffer only when no read holds it
    pop = (st.buf_cnt != 2'h0) && !st.wave_lock;
    if (pop) begin
      next_st.wave = {8'h00, st.buf_data[0]};
      set[`LVM_ST_WSMP] = 1'b1;
      next_st.buf_data[0] = st.buf_data[1];
    end
    if (push) begin
      next_st.buf_data[(pop || st.buf_cnt == 2'h0) ? 0 : 1] = wave_pick;
      if (pop && st.buf_cnt == 2'h2) begin
        next_st.buf_data[1] = wave_pick;
      end
    end
    next_st.buf_cnt = st.buf_cnt + {1'b0, push} - {1'b0, pop};
    // Source stalls while the buffer could overflow on the next sample
    next_st.in_ready = (next_st.buf_cnt != 2'h2);

    // Register writes
    if (i_req.wr) begin
      case (i_req.addr)
        `LVM_ADDR_MEASUREMENT_MODE: next_st.measurement_mode = i_req.wdata[7:0];
        `LVM_ADDR_WMODE: next_st.wmode = i_req.wdata[7:0];
        `LVM_ADDR_IRQEN: next_st.irq_en = i_req.wdata[10:0];
        `LVM_ADDR_CROSSING_TIMEOUT_RELOAD: next_st.zx_reload = i_req.wdata;
        `LVM_ADDR_DIPCYC: next_st.dip_cyc = i_req.wdata[7:0];
        `LVM_ADDR_DIPLVL: next_st.dip_lvl = i_req.wdata[7:0];
        `LVM_ADDR_VOLTAGE_PEAK_THRESHOLD: next_st.voltage_peak_threshold = i_req.wdata[7:0];
        default: next_st.measurement_mode = next_st.measurement_mode;
      endcase
    end

    // Register reads: capture a value, then hand it out a byte at a time
    if (i_req.rd) begin
      case (i_req.addr)
        `LVM_ADDR_WAVE: word = 16'h0000;
        `LVM_ADDR_PERIOD: word = {1'b0, st.period};
        `LVM_ADDR_MEASUREMENT_MODE: word = {8'h00, st.measurement_mode};
        `LVM_ADDR_WMODE: word = {8'h00, st.wmode};
        `LVM_ADDR_IRQEN: word = {5'h00, st.irq_en};
        `LVM_ADDR_STATUS: word = {5'h00, st.status};
        `LVM_ADDR_READ_CLEAR_STATUS: word = {5'h00, st.status};
        `LVM_ADDR_CROSSING_TIMEOUT_RELOAD: word = st.zx_reload;
        `LVM_ADDR_DIPCYC: word = {8'h00, st.dip_cyc};
        `LVM_ADDR_DIPLVL: word = {8'h00, st.dip_lvl};
        `LVM_ADDR_VOLTAGE_PEAK_THRESHOLD: word = {8'h00, st.voltage_peak_threshold};
        default: word = 16'h0000;
      endcase
      if (i_req.addr == `LVM_ADDR_WAVE) begin
        // Most significant byte first; lock keeps the three bytes coherent
        next_st.rd_sh = st.wave;
        next_st.rd_left = 2'h3;
        next_st.rd_wave = 1'b1;
        next_st.wave_lock = 1'b1;
      end else begin
        next_st.rd_sh = {word, 8'h00};
        next_st.rd_left = 2'h2;
        next_st.rd_wave = 1'b0;
      end
    end else if (i_req.ack && st.rd_left != 2'h0) begin
      next_st.rd_sh = {st.rd_sh[15:0], 8'h00};
      next_st.rd_left = st.rd_left - 2'h1;
      if (st.rd_left == 2'h1) begin
        next_st.wave_lock = 1'b0;
        next_st.rd_wave = 1'b0;
      end
    end

    // Flags: read-to-clear drops them, a same-cycle event still wins
    next_st.status = (rd_read_clear_status ? 11'h000 : st.status) | set;
    // Interrupt follows any enabled flag
    next_st.irq_n = ~|(next_st.status & next_st.irq_en);
    // Answer valid kept in its own flop so the pin has no logic behind it
    next_st.rsp_valid = (next_st.rd_left != 2'h0);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
      st.measurement_mode <= `LVM_RST_MEASUREMENT_MODE;
      st.wmode <= `LVM_RST_WMODE;
      st.irq_en <= `LVM_RST_IRQEN;
      st.zx_reload <= `LVM_RST_CROSSING_TIMEOUT_RELOAD;
      st.tout <= {3{`LVM_RST_CROSSING_TIMEOUT_RELOAD}};
      st.dip_cyc <= `LVM_RST_DIPCYC;
      st.dip_lvl <= `LVM_RST_DIPLVL;
      st.voltage_peak_threshold <= `LVM_RST_VOLTAGE_PEAK_THRESHOLD;
      st.in_ready <= 1'b1;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign o_vsample_ready = st.in_ready;
  assign o_mult_vbit = st.mult_bit;
  assign o_rsp = '{valid: st.rsp_valid, data: st.rd_sh[23:16]};
  assign o_irq_n = st.irq_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_wave_rd;
    i_req.rd && i_req.addr == `LVM_ADDR_WAVE;
  endsequence

  // One byte shown and taken, with no new read on top of it
  sequence s_byte_taken;
    o_rsp.valid && i_req.ack && !i_req.rd;
  endsequence

  // Start of a read from any register other than the waveform one
  sequence s_reg_rd;
    i_req.rd && i_req.addr != `LVM_ADDR_WAVE;
  endsequence

  property p_modbit;
    @(posedge i_sys_clk) disable iff (!i_nrst) ##1 o_mult_vbit == $past(i_mod_vbit);
  endproperty
  a_modbit: assert property (p_modbit) else $error("modulator bit not passed through");

  property p_upper_zero;
    @(posedge i_sys_clk) disable iff (!i_nrst) st.wave[23:16] == 8'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("waveform top byte not zero");

  property p_wave_msb;
    @(posedge i_sys_clk) disable iff (!i_nrst) s_wave_rd |=> (o_rsp.valid && o_rsp.data == $past(st.wave[23:16]));
  endproperty
  a_wave_msb: assert property (p_wave_msb) else $error("waveform first byte not msb");

  property p_zx_flag;
    @(posedge i_sys_clk) disable iff (!i_nrst) (zx_rise[0] && st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES]) |=> st.status[`LVM_ST_ZX];
  endproperty
  a_zx_flag: assert property (p_zx_flag) else $error("crossing flag not set");

  property p_rclr;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (rd_read_clear_status && zx_rise == 3'h0 && !i_vsample_valid) |=> st.status[9:7] == 3'h0;
  endproperty
  a_rclr: assert property (p_rclr) else $error("crossing flags not cleared");

  property p_zx_gate;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (!st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + 1] && !st.status[`LVM_ST_ZX + 1] && !rd_read_clear_status) |=>
      (!st.status[`LVM_ST_ZX + 1] || $past(st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + 1]));
  endproperty
  a_zx_gate: assert property (p_zx_gate) else $error("disabled phase crossing flagged");

  property p_reload;
    @(posedge i_sys_clk) disable iff (!i_nrst) zx_rise[2] |=> st.tout[2] == $past(st.zx_reload);
  endproperty
  a_reload: assert property (p_reload) else $error("timeout not reloaded");

  property p_disabled_to;
    @(posedge i_sys_clk) disable iff (!i_nrst) (!st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES]) [*2] |-> st.status[`LVM_ST_CROSSING_TIMEOUT_FLAG];
  endproperty
  a_disabled_to: assert property (p_disabled_to) else $error("disabled phase timeout flag low");

  property p_period;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (zx_rise[per_ph] && st.measurement_mode[`LVM_MM_CROSSING_PHASE_ENABLES + per_ph]) |=> st.period == $past(st.per_cnt) ##1 st.per_cnt <= 15'h0001;
  endproperty
  a_period: assert property (p_period) else $error("period not latched");

  property p_irq_hold;
    @(posedge i_sys_clk) disable iff (!i_nrst) (!o_irq_n && !rd_read_clear_status && !i_req.wr) |=> !o_irq_n;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released before clear");

  property p_irq_any;
    @(posedge i_sys_clk) disable iff (!i_nrst) (|(st.status & st.irq_en)) == !o_irq_n;
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("interrupt does not follow flags");

  // ----------------------------------------
  // Read path checks
  // ----------------------------------------
  // A waveform read hands out exactly three bytes, then the answer falls
  property p_three_bytes;
    @(posedge i_sys_clk) disable iff (!i_nrst) s_wave_rd ##1 s_byte_taken [*3] |=> !o_rsp.valid;
  endproperty
  a_three_bytes: assert property (p_three_bytes) else $error("waveform read not three bytes");

  // Every other register answers in two bytes
  property p_two_bytes;
    @(posedge i_sys_clk) disable iff (!i_nrst) s_reg_rd ##1 s_byte_taken [*2] |=> !o_rsp.valid;
  endproperty
  a_two_bytes: assert property (p_two_bytes) else $error("register read not two bytes");

  // ----------------------------------------
  // Sample path and flag checks
  // ----------------------------------------
  // In-range input keeps the smoothed code in range; a rounding slip would overshoot
  property p_fs_range;
    @(posedge i_sys_clk) disable iff (!i_nrst) (take && in_fs == 3'h7 && filt_fs == 3'h7) |=> filt_fs == 3'h7;
  endproperty
  a_fs_range: assert property (p_fs_range) else $error("smoothed code beyond full scale");

  // A word moved into the waveform register raises the new-sample flag
  property p_new_sample;
    @(posedge i_sys_clk) disable iff (!i_nrst) (st.buf_cnt != 2'h0 && !st.wave_lock) |=> st.status[`LVM_ST_WSMP];
  endproperty
  a_new_sample: assert property (p_new_sample) else $error("new sample not flagged");

  // Timeout counter only moves on a tick or a reload
  property p_tout_hold;
    @(posedge i_sys_clk) disable iff (!i_nrst) (st.tick_to != 9'h000 && !zx_rise[1]) |=> st.tout[1] == $past(st.tout[1]);
  endproperty
  a_tout_hold: assert property (p_tout_hold) else $error("timeout moved off its tick");

  // Last step of the countdown raises the timeout flag
  property p_tout_flag;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (st.tick_to == 9'h000 && st.tout[0] == 16'h0001 && !zx_rise[0]) |=> st.status[`LVM_ST_CROSSING_TIMEOUT_FLAG];
  endproperty
  a_tout_flag: assert property (p_tout_flag) else $error("timeout flag not set");

  // Enough low half cycles in a row raise the dip flag of that phase
  property p_dip_flag;
    @(posedge i_sys_clk) disable iff (!i_nrst)
      (take && st.filt[2][15] != st.prev_neg[2] && st.all_below[2] && st.dip_cnt[2] + 8'h01 == st.dip_cyc) |=>
      st.status[`LVM_ST_DIP + 2];
  endproperty
  a_dip_flag: assert property (p_dip_flag) else $error("dip flag not set");

  // Selected phase above the threshold raises the voltage peak flag
  property p_peak_flag;
    @(posedge i_sys_clk) disable iff (!i_nrst) (take && vabs[pk_ph] > {1'b0, st.voltage_peak_threshold}) |=> st.status[`LVM_ST_PKV];
  endproperty
  a_peak_flag: assert property (p_peak_flag) else $error("voltage peak flag not set");

endmodule

// ### lvm_pkg.sv
// Types shared by the voltage event monitor
package lvm_pkg;

  // Register read and write request
  typedef struct packed {
    logic wr;
    logic rd;
    logic ack;
    logic [5:0] addr;
    logic [15:0] wdata;
  } lvm_req_t;

  // Byte-serial read answer
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } lvm_rsp_t;

  // Whole module state
  typedef struct packed {
    logic [2:0][15:0] filt;
    logic [2:0] prev_neg;
    logic [2:0] all_below;
    logic [2:0][7:0] dip_cnt;
    logic [2:0][15:0] tout;
    logic [8:0] tick_to;
    logic [4:0] tick_per;
    logic [14:0] per_cnt;
    logic [14:0] period;
    logic [10:0] status;
    logic [10:0] irq_en;
    logic [7:0] measurement_mode;
    logic [7:0] wmode;
    logic [15:0] zx_reload;
    logic [7:0] dip_lvl;
    logic [7:0] dip_cyc;
    logic [7:0] voltage_peak_threshold;
    logic [2:0] dec_cnt;
    logic [1:0][15:0] buf_data;
    logic [1:0] buf_cnt;
    logic [23:0] wave;
    logic wave_lock;
    logic [23:0] rd_sh;
    logic [1:0] rd_left;
    logic rd_wave;
    logic rsp_valid;
    logic in_ready;
    logic [2:0] mult_bit;
    logic irq_n;
  } lvm_state_t;

endpackage

// ### lvm_regs.svh
// Register offsets, field positions, reset values and timing counts of the voltage event monitor
`ifndef LVM_REGS_SVH
`define LVM_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LVM_ADDR_WAVE 6'h01
`define LVM_ADDR_PERIOD 6'h07
`define LVM_ADDR_MEASUREMENT_MODE 6'h0b
`define LVM_ADDR_WMODE 6'h0d
`define LVM_ADDR_IRQEN 6'h0f
`define LVM_ADDR_STATUS 6'h10
`define LVM_ADDR_READ_CLEAR_STATUS 6'h11
`define LVM_ADDR_CROSSING_TIMEOUT_RELOAD 6'h12
`define LVM_ADDR_DIPCYC 6'h14
`define LVM_ADDR_DIPLVL 6'h15
`define LVM_ADDR_VOLTAGE_PEAK_THRESHOLD 6'h16

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LVM_ST_WSMP 0
`define LVM_ST_DIP 1
`define LVM_ST_CROSSING_TIMEOUT_FLAG 4
`define LVM_ST_ZX 7
`define LVM_ST_PKV 10
`define LVM_MM_PERSEL 0
`define LVM_MM_PKSEL 2
`define LVM_MM_CROSSING_PHASE_ENABLES 4
`define LVM_WM_PHSEL 0
`define LVM_WM_RATE 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LVM_RST_MEASUREMENT_MODE 8'h70
`define LVM_RST_WMODE 8'h00
`define LVM_RST_IRQEN 11'h000
`define LVM_RST_CROSSING_TIMEOUT_RELOAD 16'hffff
`define LVM_RST_DIPCYC 8'hff
`define LVM_RST_DIPLVL 8'h00
`define LVM_RST_VOLTAGE_PEAK_THRESHOLD 8'hff

// ----------------------------------------
// Timing counts, in master clock periods, and full-scale sample code limits
// ----------------------------------------
`define LVM_TOUT_TICK 384
`define LVM_PER_TICK 24
`define LVM_FS_MAX 16'h28f5
`define LVM_FS_MIN 16'hd70b

`endif

// ### tb_top.sv
// Self-checking bench of the voltage event monitor
`timescale 1ns/1ps
`include "lvm_regs.svh"
module tb_top
  import lvm_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_vsample_valid = 1'b0;
  logic [2:0][15:0] i_vsample = '0;
  logic [2:0] i_mod_vbit = '0;
  lvm_req_t req;
  lvm_rsp_t rsp;
  logic rdy;
  logic [2:0] mult;
  logic irq_n;
  logic [23:0] v;
  int err_total = 0;
  int checks = 0;
  // ----------------------------------------
  // Clock, design and host
  // ----------------------------------------
  // 40 MHz master clock
  always #12.5 i_sys_clk = ~i_sys_clk;
  lvm_monitor lvm_monitor_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_vsample_valid(i_vsample_valid),
    .i_vsample(i_vsample), .i_mod_vbit(i_mod_vbit), .i_req(req), .o_vsample_ready(rdy),
    .o_mult_vbit(mult), .o_rsp(rsp), .o_irq_n(irq_n));
  lvm_host_model lvm_host_model_i (.i_sys_clk(i_sys_clk), .i_rsp(rsp), .o_req(req));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Compare a register value
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // Compare a pin or a flag
  task automatic chk_pin(input logic got, input logic exp);
    chk_val({23'h0, got}, {23'h0, exp});
  endtask
  // Wait edges, land just after the last one
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    lvm_host_model_i.write_reg(a, d);
  endtask
  task automatic rd(input logic [5:0] a, input int n);
    lvm_host_model_i.read_reg(a, n, v);
  endtask
  // Clearing read; the clear lands a cycle later
  task automatic clr();
    rd(`LVM_ADDR_READ_CLEAR_STATUS, 2);
    cyc(2);
  endtask
  // Two cycles a sample while ready, so timing stays exact
  task automatic feed(input logic [15:0] a, b, c, input int n);
    int w;
    for (int i = 0; i < n; i++) begin
      i_vsample_valid = 1'b1;
      i_vsample = {c, b, a};
      w = 0;
      while (rdy !== 1'b1 && w < 50) begin
        cyc(1);
        w++;
      end
      cyc(1);
      i_vsample_valid = 1'b0;
      cyc(1);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [5:0] ad [7] = '{`LVM_ADDR_MEASUREMENT_MODE, `LVM_ADDR_CROSSING_TIMEOUT_RELOAD, `LVM_ADDR_DIPCYC, `LVM_ADDR_DIPLVL,
      `LVM_ADDR_VOLTAGE_PEAK_THRESHOLD, `LVM_ADDR_IRQEN, 6'h3f};
    logic [15:0] ex [7] = '{16'h0070, 16'hffff, 16'h00ff, 16'h0000, 16'h00ff, 16'h0000, 16'h0000};
    chk_pin(irq_n, 1'b1);
    chk_pin(rdy, 1'b1);
    for (int i = 0; i < 7; i++) begin
      rd(ad[i], 2);
      chk_val(v, {8'h00, ex[i]});
    end
    wr(`LVM_ADDR_CROSSING_TIMEOUT_RELOAD, 16'h0003);
    wr(6'h3e, 16'h1234);
    rd(`LVM_ADDR_CROSSING_TIMEOUT_RELOAD, 2);
    chk_val(v, 24'h000003);
    rd(6'h3e, 2);
    chk_val(v, 24'h000000);
  endtask
  task automatic t_wave();
    wr(`LVM_ADDR_IRQEN, 16'h0001);
    feed(16'he000, 16'he000, 16'he000, 20);
    chk_pin(irq_n, 1'b0);
    rd(`LVM_ADDR_WAVE, 3);
    chk_val({v[23:15], 15'h0}, 24'h008000);
    rd(`LVM_ADDR_STATUS, 2);
    chk_pin(irq_n, 1'b0);
    clr();
    chk_pin(irq_n, 1'b1);
    wr(`LVM_ADDR_IRQEN, 16'h0000);
    i_mod_vbit = 3'h5;
    cyc(1);
    chk_pin(mult === 3'h5, 1'b1);
  endtask
  // Each rate keeps one sample in 1, 2, 4 or 8
  task automatic t_rate();
    int n;
    for (int r = 0; r < 4; r++) begin
      wr(`LVM_ADDR_WMODE, 16'(r << 3));
      clr();
      n = 0;
      for (int i = 0; i < 16; i++) begin
        feed(16'he000, 16'he000, 16'he000, 1);
        cyc(2);
        rd(`LVM_ADDR_READ_CLEAR_STATUS, 2);
        n += int'(v[0] === 1'b1);
      end
      chk_val(24'(n), 24'(16 >> r));
    end
  endtask
  // Rising crossing on A, then its short timeout runs out
  task automatic t_cross();
    wr(`LVM_ADDR_IRQEN, 16'h0090);
    feed(16'h2000, 16'he000, 16'he000, 40);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h80, 24'h80);
    chk_pin(irq_n, 1'b0);
    clr();
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h90, 24'h00);
    cyc(400);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h10, 24'h00);
    cyc(1200);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h10, 24'h10);
    chk_pin(irq_n, 1'b0);
  endtask
  // Only A enabled: B and C time out for good, B crossing stays quiet
  task automatic t_sel();
    wr(`LVM_ADDR_MEASUREMENT_MODE, 16'h0010);
    wr(`LVM_ADDR_IRQEN, 16'h0100);
    clr();
    feed(16'h2000, 16'h2000, 16'he000, 40);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h60, 24'h60);
    chk_pin(irq_n, 1'b1);
  endtask
  // 240-cycle square wave on A gives ten counts, one of slack for tick phase
  task automatic t_period();
    wr(`LVM_ADDR_MEASUREMENT_MODE, 16'h0070);
    repeat (4) begin
      feed(16'he000, 16'he000, 16'he000, 60);
      feed(16'h2000, 16'he000, 16'he000, 60);
    end
    rd(`LVM_ADDR_PERIOD, 2);
    chk_pin(v >= 24'd9 && v <= 24'd11, 1'b1);
  endtask
  task automatic t_peak();
    wr(`LVM_ADDR_MEASUREMENT_MODE, 16'h0074);
    wr(`LVM_ADDR_VOLTAGE_PEAK_THRESHOLD, 16'h0010);
    wr(`LVM_ADDR_IRQEN, 16'h0400);
    feed(16'h2800, 16'h0100, 16'h0100, 40);
    clr();
    feed(16'h2800, 16'h0100, 16'h0100, 4);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h400, 24'h000);
    chk_pin(irq_n, 1'b1);
    feed(16'h2800, 16'hd800, 16'h0100, 40);
    rd(`LVM_ADDR_STATUS, 2);
    chk_val(v & 24'h400, 24'h400);
    chk_pin(irq_n, 1'b0);
  endtask
  // Small wave on all phases: no dip at level 0, dip at level 0x28
  task automatic t_dip();
    wr(`LVM_ADDR_MEASUREMENT_MODE, 16'h0070);
    wr(`LVM_ADDR_DIPCYC, 16'h0002);
    wr(`LVM_ADDR_IRQEN, 16'h000e);
    for (int k = 0; k < 2; k++) begin
      wr(`LVM_ADDR_DIPLVL, k ? 16'h0028 : 16'h0000);
      clr();
      repeat (3) begin
        feed(16'h0100, 16'h0100, 16'h0100, 30);
        feed(16'hff00, 16'hff00, 16'hff00, 30);
      end
      rd(`LVM_ADDR_STATUS, 2);
      chk_val(v & 24'he, k ? 24'he : 24'h0);
    end
    chk_pin(irq_n, 1'b0);
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic complete_run();
    err_total += lvm_host_model_i.proto_err;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Reset for 12 cycles, then the scenarios in turn
  initial begin
    cyc(12);
    i_nrst = 1'b1;
    t_reset();
    t_wave();
    t_rate();
    t_cross();
    t_sel();
    t_period();
    t_peak();
    t_dip();
    complete_run();
  end
  // Watchdog, about 18 times the roughly 4.4k cycles the run needs
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    err_total++;
    complete_run();
  end
endmodule
